// ===== verilog/pab_master.sv
// AXI4 master port of the bridge: issues bursts for inbound requests
`timescale 1ns/1ps
`include "pab_regs.svh"

// Rules for this block and its attached slave
// [RULE1] Write user sideband is driven constantly low whenever it is not in use.
// [RULE2] User sidebands work only with parity forwarding, never in the gen3-only variant.
// [RULE3] Attached slave holds read user sideband low; it is ignored when unused.
// [RULE4] Read size equals the full data width, except one-dword requests.
// [RULE5] At 128 bits: one dword gives size 2, two dwords give size 4.
// [RULE6] Slaves with destructive reads must beware of reads wider than requested.
// [RULE7] No multi-beat narrow bursts; narrow transfers are single beat only.
// [RULE8] Read address handshake proceeds only while bus master enable is set; the code gates only arvalid rising, a raised one completes regardless.
// [RULE9] Slaves must honour write strobes and update only enabled byte lanes.
// [RULE10] All channels use valid/ready; last flag marks the final write beat.
module pab_master #(
   parameter int ADDR_W = 32,
   parameter int DATA_W = 128,
   parameter int FIFO_DEPTH = 32,
   parameter bit PARITY_FWD = 1'b0,
   parameter bit GEN3_ONLY = 1'b0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic bus_master_en,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [10:0] req_dwords,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [DATA_W/8-1:0] wr_strb,
   output logic wr_done,
   output logic [1:0] wr_resp,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [DATA_W-1:0] rd_data,
   output logic [1:0] rd_resp,
   output logic rd_last,
   output logic [DATA_W/8-1:0] rd_user,
   output logic [ADDR_W-1:0] m_axi_awaddr,
   output logic [7:0] m_axi_awlen,
   output logic [2:0] m_axi_awsize,
   output logic [1:0] m_axi_awburst,
   output logic [2:0] m_axi_awprot,
   output logic m_axi_awvalid,
   input wire logic m_axi_awready,
   output logic [DATA_W-1:0] m_axi_wdata,
   output logic [DATA_W/8-1:0] m_axi_wstrb,
   output logic m_axi_wlast,
   output logic m_axi_wvalid,
   input wire logic m_axi_wready,
   output logic [DATA_W/8-1:0] m_axi_wuser,
   input wire logic [1:0] m_axi_bresp,
   input wire logic m_axi_bvalid,
   output logic m_axi_bready,
   output logic [ADDR_W-1:0] m_axi_araddr,
   output logic [7:0] m_axi_arlen,
   output logic [2:0] m_axi_arsize,
   output logic [1:0] m_axi_arburst,
   output logic [2:0] m_axi_arprot,
   output logic m_axi_arvalid,
   input wire logic m_axi_arready,
   input wire logic [DATA_W-1:0] m_axi_rdata,
   input wire logic [1:0] m_axi_rresp,
   input wire logic m_axi_rlast,
   input wire logic m_axi_rvalid,
   output logic m_axi_rready,
   input wire logic [DATA_W/8-1:0] m_axi_ruser
);
   localparam int BPB = DATA_W / 8;
   localparam int LSB = $clog2(BPB);
   localparam logic [2:0] SIZE_FULL = 3'(LSB);
   localparam bit USER_EN = PARITY_FWD && !GEN3_ONLY;
   localparam int FW = DATA_W + BPB;

   generate
      if (DATA_W < 32 || DATA_W > 1024 || (DATA_W & (DATA_W - 1)) != 0 || ADDR_W < 13)
      begin : g_bad
         $error("pab_master: DATA_W must be a power of two in 32..1024, ADDR_W >= 13");
      end
   endgenerate

   // ----------------------------------------
   // Burst encoding
   // ----------------------------------------
   // One dword is the only narrow case
   function automatic logic [2:0] burst_size(input logic [10:0] dw);
      burst_size = (dw == `PAB_ONE_DW) ? `PAB_SIZE_1DW : SIZE_FULL;
   endfunction

   // Beats covering address offset plus length, minus one
   function automatic logic [7:0] burst_len(input logic [ADDR_W-1:0] a,
                                            input logic [10:0] dw);
      logic [12:0] span;
      span = 13'(a[LSB-1:0]) + 13'(dw * `PAB_DW_BYTES) + 13'(BPB - 1);
      burst_len = (dw == `PAB_ONE_DW) ? `PAB_LEN_ZERO : 8'((span >> LSB) - 13'h0001);
   endfunction

   function automatic logic [BPB-1:0] byte_parity(input logic [DATA_W-1:0] d);
      logic [BPB-1:0] p;
      p = '0;
      for (int i = 0; i < BPB; i++) begin
         p[i] = ^d[8*i +: 8];
      end
      byte_parity = p;
   endfunction

   // ----------------------------------------
   // Write data FIFO
   // ----------------------------------------
   logic fifo_out_valid, fifo_out_ready;
   logic [FW-1:0] fifo_out_data;

   pab_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data({wr_strb, wr_data}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   pab_pkg::pab_state_e state, next_state;
   logic [7:0] beats_left, next_beats_left;
   logic next_req_ready, next_wr_done, next_rd_valid, next_rd_last;
   logic [1:0] next_wr_resp, next_rd_resp;
   logic [DATA_W-1:0] next_rd_data;
   logic [BPB-1:0] next_rd_user;
   logic [ADDR_W-1:0] next_addr;
   logic [7:0] next_len;
   logic [2:0] next_size;
   logic next_awvalid, next_wvalid, next_wlast, next_bready, next_arvalid, next_rready;
   logic [DATA_W-1:0] next_wdata;
   logic [BPB-1:0] next_wstrb, next_wuser;

   always_comb begin
      next_state = state;
      next_beats_left = beats_left;
      next_req_ready = req_ready;
      next_wr_done = 1'b0;
      next_wr_resp = wr_resp;
      next_rd_valid = (rd_valid && rd_ready) ? 1'b0 : rd_valid;
      next_rd_data = rd_data;
      next_rd_resp = rd_resp;
      next_rd_last = rd_last;
      next_rd_user = rd_user;
      next_addr = m_axi_awaddr;
      next_len = m_axi_awlen;
      next_size = m_axi_awsize;
      next_awvalid = m_axi_awvalid;
      next_wvalid = m_axi_wvalid;
      next_wlast = m_axi_wlast;
      next_wdata = m_axi_wdata;
      next_wstrb = m_axi_wstrb;
      next_wuser = m_axi_wuser;
      next_bready = m_axi_bready;
      next_arvalid = m_axi_arvalid;
      next_rready = m_axi_rready;
      fifo_out_ready = 1'b0;
      unique case (state)
         pab_pkg::PAB_IDLE: begin
            // Ready rises in idle even while a request already waits
            next_req_ready = 1'b1;
            if (req_valid && req_ready) begin
               next_addr = req_addr;
               next_len = burst_len(req_addr, req_dwords); // [RULE7]
               next_size = burst_size(req_dwords); // [RULE4] [RULE5]
               next_beats_left = next_len;
               next_req_ready = 1'b0;
               if (req_write) begin
                  next_state = pab_pkg::PAB_AW;
                  next_awvalid = 1'b1;
               end else begin
                  next_state = pab_pkg::PAB_AR;
               end
            end
         end
         pab_pkg::PAB_AW: begin
            if (m_axi_awvalid && m_axi_awready) begin // [RULE10]
               next_awvalid = 1'b0;
               next_state = pab_pkg::PAB_W;
            end
         end
         pab_pkg::PAB_W: begin
            // Pull a beat when the output slot frees and last is not yet loaded
            fifo_out_ready = fifo_out_valid && (!m_axi_wvalid || (m_axi_wready && !m_axi_wlast));
            if (fifo_out_ready) begin
               next_wvalid = 1'b1;
               next_wdata = fifo_out_data[DATA_W-1:0];
               next_wstrb = fifo_out_data[FW-1:DATA_W];
               next_wlast = (beats_left == `PAB_LEN_ZERO); // [RULE10]
               next_wuser = USER_EN ? byte_parity(fifo_out_data[DATA_W-1:0]) : '0; // [RULE1]
               next_beats_left = 8'(beats_left - 1'b1);
            end else if (m_axi_wvalid && m_axi_wready) begin
               next_wvalid = 1'b0;
               if (m_axi_wlast) begin
                  next_wlast = 1'b0;
                  next_bready = 1'b1;
                  next_state = pab_pkg::PAB_B;
               end
            end
         end
         pab_pkg::PAB_B: begin
            if (m_axi_bvalid && m_axi_bready) begin
               next_bready = 1'b0;
               next_wr_done = 1'b1;
               next_wr_resp = m_axi_bresp;
               next_state = pab_pkg::PAB_IDLE;
               next_req_ready = 1'b1;
            end
         end
         pab_pkg::PAB_AR: begin
            if (m_axi_arvalid && m_axi_arready) begin
               next_arvalid = 1'b0;
               next_rready = !next_rd_valid;
               next_state = pab_pkg::PAB_R;
            end else if (!m_axi_arvalid && bus_master_en) begin
               next_arvalid = 1'b1; // [RULE8]
            end
         end
         pab_pkg::PAB_R: begin
            if (m_axi_rvalid && m_axi_rready) begin
               next_rd_valid = 1'b1;
               next_rd_data = m_axi_rdata;
               next_rd_resp = m_axi_rresp;
               next_rd_last = m_axi_rlast;
               next_rd_user = USER_EN ? m_axi_ruser : '0; // [RULE2] [RULE3]
               if (m_axi_rlast) begin
                  next_state = pab_pkg::PAB_IDLE;
                  next_req_ready = 1'b1;
               end
            end
            // One-entry return slot: accept a beat only when it is free
            next_rready = (next_state == pab_pkg::PAB_R) && !next_rd_valid;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= pab_pkg::PAB_IDLE;
         beats_left <= '0;
         req_ready <= 1'b0;
         wr_done <= 1'b0;
         wr_resp <= `PAB_RESP_OKAY;
         rd_valid <= 1'b0;
         rd_data <= '0;
         rd_resp <= `PAB_RESP_OKAY;
         rd_last <= 1'b0;
         rd_user <= '0;
         m_axi_awaddr <= '0;
         m_axi_awlen <= '0;
         m_axi_awsize <= '0;
         m_axi_awvalid <= 1'b0;
         m_axi_wdata <= '0;
         m_axi_wstrb <= '0;
         m_axi_wlast <= 1'b0;
         m_axi_wvalid <= 1'b0;
         m_axi_wuser <= '0;
         m_axi_bready <= 1'b0;
         m_axi_arvalid <= 1'b0;
         m_axi_rready <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         beats_left <= next_beats_left;
         req_ready <= next_req_ready;
         wr_done <= next_wr_done;
         wr_resp <= next_wr_resp;
         rd_valid <= next_rd_valid;
         rd_data <= next_rd_data;
         rd_resp <= next_rd_resp;
         rd_last <= next_rd_last;
         rd_user <= next_rd_user;
         m_axi_awaddr <= next_addr;
         m_axi_awlen <= next_len;
         m_axi_awsize <= next_size;
         m_axi_awvalid <= next_awvalid;
         m_axi_wdata <= next_wdata;
         m_axi_wstrb <= next_wstrb;
         m_axi_wlast <= next_wlast;
         m_axi_wvalid <= next_wvalid;
         m_axi_wuser <= next_wuser;
         m_axi_bready <= next_bready;
         m_axi_arvalid <= next_arvalid;
         m_axi_rready <= next_rready;
      end
   end

   // ----------------------------------------
   // Address channels share one captured request
   // ----------------------------------------
   always_comb begin
      m_axi_araddr = m_axi_awaddr;
      m_axi_arlen = m_axi_awlen;
      m_axi_arsize = m_axi_awsize;
   end

   always_ff @(posedge clock) begin
      m_axi_awburst <= `PAB_BURST_INCR;
      m_axi_arburst <= `PAB_BURST_INCR;
      m_axi_awprot <= `PAB_PROT_DATA;
      m_axi_arprot <= `PAB_PROT_DATA;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [10:0] dw_q;
   logic [7:0] w_seen;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dw_q <= '0;
         w_seen <= '0;
      end else if (ce) begin
         if (req_valid && req_ready) begin
            dw_q <= req_dwords;
            w_seen <= '0;
         end else if (m_axi_wvalid && m_axi_wready) begin
            w_seen <= 8'(w_seen + 1'b1);
         end
      end
   end

   a_wuser_low: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
      !USER_EN |-> m_axi_wuser == '0) else $error("wuser not low while unused");
   a_ruser_gated: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
      rd_valid && !USER_EN |-> rd_user == '0) else $error("read user passed while disabled");
   a_read_size_full: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
      m_axi_arvalid |-> (dw_q == `PAB_ONE_DW) ? (m_axi_arsize == `PAB_SIZE_1DW)
                                              : (m_axi_arsize == SIZE_FULL))
      else $error("read size not full width");
   a_write_size_code: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
      m_axi_awvalid |-> (dw_q == `PAB_ONE_DW) ? (m_axi_awsize == `PAB_SIZE_1DW)
                                              : (m_axi_awsize == SIZE_FULL))
      else $error("write size code wrong");
   a_no_narrow_burst: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
      (m_axi_awvalid || m_axi_arvalid) && m_axi_awsize != SIZE_FULL |-> m_axi_awlen == '0)
      else $error("multi-beat narrow burst");
   a_ar_needs_bme: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
      $rose(m_axi_arvalid) |-> $past(bus_master_en)) else $error("read issued without bme");
   a_wlast_count: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
      m_axi_wvalid && m_axi_wready && m_axi_wlast |-> w_seen == m_axi_awlen ##1 !m_axi_wvalid)
      else $error("wlast not on final beat");
   a_aw_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
      m_axi_awvalid && !m_axi_awready && ce |=> m_axi_awvalid && $stable(m_axi_awaddr))
      else $error("awvalid dropped before ready");
   a_ar_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
      m_axi_arvalid && !m_axi_arready && ce |=> m_axi_arvalid && $stable(m_axi_arlen))
      else $error("arvalid dropped before ready");

endmodule

// ===== verilog/pab_regs.svh
// Fixed encodings and field values of the bridge master port
`ifndef PAB_REGS_SVH
`define PAB_REGS_SVH

// ----------------------------------------
// Burst, protection and response encodings
// ----------------------------------------
`define PAB_SIZE_1DW 3'h2
`define PAB_BURST_INCR 2'h1
`define PAB_PROT_DATA 3'h0
`define PAB_RESP_OKAY 2'h0

// ----------------------------------------
// Length arithmetic
// ----------------------------------------
`define PAB_DW_BYTES 13'h0004
`define PAB_ONE_DW 11'h001
`define PAB_LEN_ZERO 8'h00

`endif

// ===== verilog/pab_pkg.sv
// Types shared by the bridge master port files
package pab_pkg;

   // ----------------------------------------
   // Transfer sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      PAB_IDLE,
      PAB_AW,
      PAB_W,
      PAB_B,
      PAB_AR,
      PAB_R
   } pab_state_e;

endpackage

// ===== verilog/pab_fifo.sv
// Write data FIFO with registered output stage
`timescale 1ns/1ps

module pab_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
         $error("pab_fifo: DEPTH must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic next_in_ready, next_out_valid;
   logic push, load;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      push = in_valid && in_ready;
      load = (count != '0) && (!out_valid || out_ready);
      next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = load ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_count = count;
      if (push && !load) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (!push && load) begin
         next_count = (AW+1)'(count - 1'b1);
      end
      next_out_valid = load ? 1'b1 : (out_ready ? 1'b0 : out_valid);
      // Registered ready: full stalls the source
      next_in_ready = next_count < (AW+1)'(DEPTH);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else if (ce) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         in_ready <= next_in_ready;
         out_valid <= next_out_valid;
      end
   end

   always_ff @(posedge clock) begin
      if (ce && push) begin
         mem[wr_ptr] <= in_data;
      end
      if (!rst_n) begin
         out_data <= '0;
      end else if (ce && load) begin
         out_data <= mem[rd_ptr];
      end
   end

endmodule

// ===== tb/pab_slave_model.sv
// Behavioural AXI4 slave memory facing the bridge master port
`timescale 1ns/1ps

module pab_slave_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic [31:0] m_axi_awaddr,
   input wire logic m_axi_awvalid,
   output logic m_axi_awready,
   input wire logic [127:0] m_axi_wdata,
   input wire logic [15:0] m_axi_wstrb,
   input wire logic m_axi_wlast,
   input wire logic m_axi_wvalid,
   output logic m_axi_wready,
   output logic [1:0] m_axi_bresp,
   output logic m_axi_bvalid,
   input wire logic m_axi_bready,
   input wire logic [31:0] m_axi_araddr,
   input wire logic [7:0] m_axi_arlen,
   input wire logic m_axi_arvalid,
   output logic m_axi_arready,
   output logic [127:0] m_axi_rdata,
   output logic [1:0] m_axi_rresp,
   output logic m_axi_rlast,
   output logic m_axi_rvalid,
   input wire logic m_axi_rready,
   output logic [15:0] m_axi_ruser
);
   logic [127:0] mem [16];
   logic [3:0] widx, ridx;
   logic [7:0] rcnt;
   logic tick;

   // Slow mode stalls every other cycle
   assign m_axi_awready = !slow || tick;
   assign m_axi_wready = !slow || tick;
   assign m_axi_arready = !slow || tick;
   assign m_axi_bresp = 2'h0;
   assign m_axi_rresp = 2'h0;
   assign m_axi_ruser = 16'h0000;
   // Whole entry is returned; reads have no side effect
   assign m_axi_rdata = m_axi_rvalid ? mem[ridx] : ~mem[ridx];
   assign m_axi_rlast = m_axi_rvalid && (rcnt == 8'h00);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tick <= 1'b0;
         m_axi_bvalid <= 1'b0;
         m_axi_rvalid <= 1'b0;
      end else begin
         tick <= !tick;
         if (m_axi_awvalid && m_axi_awready) begin
            widx <= m_axi_awaddr[7:4];
         end
         if (m_axi_wvalid && m_axi_wready) begin
            for (int i = 0; i < 16; i++) begin
               if (m_axi_wstrb[i]) begin
                  mem[widx][8*i +: 8] <= m_axi_wdata[8*i +: 8];
               end
            end
            widx <= widx + 4'h1;
            if (m_axi_wlast) begin
               m_axi_bvalid <= 1'b1;
            end
         end
         if (m_axi_bvalid && m_axi_bready) begin
            m_axi_bvalid <= 1'b0;
         end
         if (m_axi_arvalid && m_axi_arready) begin
            ridx <= m_axi_araddr[7:4];
            rcnt <= m_axi_arlen;
            m_axi_rvalid <= 1'b1;
         end else if (m_axi_rvalid && m_axi_rready) begin
            if (rcnt == 8'h00) begin
               m_axi_rvalid <= 1'b0;
            end else begin
               ridx <= ridx + 4'h1;
               rcnt <= rcnt - 8'h01;
            end
         end
      end
   end
endmodule

// ===== tb/tb.sv
// Self-checking testbench of the bridge master port
`timescale 1ns/1ps

module tb;
   logic clock, rst_n, ce, bus_master_en, req_valid, req_ready, req_write, slow;
   logic wr_valid, wr_ready, wr_done, rd_valid, rd_ready, rd_last;
   logic [31:0] req_addr, m_axi_awaddr, m_axi_araddr, seq;
   logic [10:0] req_dwords;
   logic [127:0] wr_data, rd_data, m_axi_wdata, m_axi_rdata;
   logic [127:0] exp_mem [16];
   logic [15:0] wr_strb, rd_user, m_axi_wstrb, m_axi_wuser, m_axi_ruser;
   logic [1:0] wr_resp, rd_resp, m_axi_awburst, m_axi_arburst, m_axi_bresp, m_axi_rresp;
   logic [7:0] m_axi_awlen, m_axi_arlen, aw_len, ar_len, wcnt;
   logic [2:0] m_axi_awsize, m_axi_arsize, m_axi_awprot, m_axi_arprot, aw_size, ar_size;
   logic m_axi_awvalid, m_axi_awready, m_axi_wlast, m_axi_wvalid, m_axi_wready;
   logic m_axi_bvalid, m_axi_bready, m_axi_arvalid, m_axi_arready;
   logic m_axi_rlast, m_axi_rvalid, m_axi_rready;
   int miscompares, checks, bad_last, bad_user, bad_narrow;

   pab_master #(.FIFO_DEPTH(32)) u_pab_master (.*);
   pab_slave_model u_pab_slave_model (.*);

   always #2.5 clock = ~clock;

   // ----------------------------------------
   // Port monitor
   // ----------------------------------------
   always @(posedge clock) begin
      if (m_axi_awvalid && m_axi_awready) begin
         aw_len <= m_axi_awlen;
         aw_size <= m_axi_awsize;
      end
      if (m_axi_arvalid && m_axi_arready) begin
         ar_len <= m_axi_arlen;
         ar_size <= m_axi_arsize;
      end
      if (m_axi_wvalid && m_axi_wready) begin
         if (m_axi_wlast !== (wcnt == aw_len)) bad_last++;
         wcnt <= m_axi_wlast ? 8'h00 : wcnt + 8'h01;
      end
      if (m_axi_wvalid && m_axi_wuser !== 16'h0000) bad_user++;
      if (m_axi_awvalid && m_axi_awlen != 8'h00 && m_axi_awsize !== 3'h4) bad_narrow++;
      if (m_axi_arvalid && m_axi_arlen != 8'h00 && m_axi_arsize !== 3'h4) bad_narrow++;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic request(input logic w, input logic [31:0] a, input logic [10:0] dw);
      int i;
      @(negedge clock);
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_dwords = dw;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (req_ready !== 1'b1 && i < 100);
      check("req_taken", i < 100, 1'b1);
      @(negedge clock);
      req_valid = 1'b0;
   endtask

   task automatic wait_done();
      int i;
      i = 0;
      do begin
         @(negedge clock);
         i++;
      end while (wr_done !== 1'b1 && i < 400);
      check("wr_done", wr_done, 1'b1);
      check("wr_resp", wr_resp, 2'h0);
   endtask

   task automatic wr_xfer(input logic [31:0] a, input logic [10:0] dw, input logic [15:0] s);
      int beats;
      int idx;
      beats = (a % 16 + 4 * dw + 15) / 16;
      idx = a[7:4];
      for (int b = 0; b < beats; b++) begin
         @(negedge clock);
         wr_valid = 1'b1;
         wr_data = {4{seq}};
         wr_strb = s;
         do @(posedge clock); while (wr_ready !== 1'b1);
         for (int i = 0; i < 16; i++) begin
            if (s[i]) exp_mem[(idx + b) % 16][8*i +: 8] = wr_data[8*i +: 8];
         end
         seq++;
      end
      @(negedge clock);
      wr_valid = 1'b0;
      request(1'b1, a, dw);
      wait_done();
      check("aw_size", aw_size, (dw == 1) ? 3'h2 : 3'h4);
      check("aw_len", aw_len, beats - 1);
      check("awaddr", m_axi_awaddr, a);
   endtask

   task automatic rd_xfer(input logic [31:0] a, input logic [10:0] dw, input logic hold);
      int beats;
      int i;
      beats = (a % 16 + 4 * dw + 15) / 16;
      if (hold) bus_master_en = 1'b0;
      request(1'b0, a, dw);
      if (hold) begin
         repeat (10) @(negedge clock) check("arvalid", m_axi_arvalid, 1'b0);
         bus_master_en = 1'b1;
         // Clock enable low freezes the pending read address
         ce = 1'b0;
         repeat (4) @(negedge clock) check("ce_freeze", m_axi_arvalid, 1'b0);
         ce = 1'b1;
      end
      for (int b = 0; b < beats; b++) begin
         i = 0;
         do begin
            @(negedge clock);
            i++;
         end while (!(rd_valid === 1'b1) && i < 200);
         check("rd_valid", rd_valid, 1'b1);
         check("rd_resp", rd_resp, 2'h0);
         check("rd_data", rd_data, exp_mem[(a[7:4] + b) % 16]);
         check("rd_last", rd_last, b == beats - 1);
         check("rd_user", rd_user, 16'h0000);
      end
      check("ar_size", ar_size, (dw == 1) ? 3'h2 : 3'h4);
      check("ar_len", ar_len, beats - 1);
      check("araddr", m_axi_araddr, a);
   endtask

   task automatic check_mon();
      check("wlast", bad_last, 0);
      check("wuser", bad_user, 0);
      check("narrow", bad_narrow, 0);
      check("burst_prot", {m_axi_awburst, m_axi_arburst, m_axi_awprot, m_axi_arprot}, 10'h140);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_fifo_fill();
      int n;
      n = 0;
      for (int i = 0; i < 40; i++) begin
         @(negedge clock);
         wr_valid = 1'b1;
         wr_data = {4{seq}};
         wr_strb = 16'hffff;
         @(posedge clock);
         if (wr_ready !== 1'b1) break;
         exp_mem[n % 16] = wr_data;
         n++;
         seq++;
      end
      @(negedge clock);
      wr_valid = 1'b0;
      check("fifo_full", n >= 32, 1'b1);
      slow = 1'b1;
      request(1'b1, 32'h0000_0000, n * 4);
      wait_done();
      check("aw_len", aw_len, n - 1);
      check("aw_size", aw_size, 3'h4);
      check("wr_ready", wr_ready, 1'b1);
      rd_xfer(32'h0000_0040, 11'h008, 1'b0);
      slow = 1'b0;
      check_mon();
      $display("test fifo_fill done");
   endtask

   task automatic test_one_dword();
      wr_xfer(32'h0000_0014, 11'h001, 16'h00f0);
      rd_xfer(32'h0000_0014, 11'h001, 1'b0);
      check_mon();
      $display("test one_dword done");
   endtask

   task automatic test_two_dword_bme();
      wr_xfer(32'h0000_0020, 11'h008, 16'hffff);
      rd_xfer(32'h0000_0020, 11'h002, 1'b1);
      check_mon();
      $display("test two_dword_bme done");
   endtask

   task automatic test_strobe_mask();
      wr_xfer(32'h0000_0030, 11'h001, 16'h000f);
      rd_xfer(32'h0000_0030, 11'h008, 1'b0);
      check_mon();
      $display("test strobe_mask done");
   endtask

   initial begin
      #100000;
      miscompares++;
      print_verdict();
   end

   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      bus_master_en = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 32'h0000_0000;
      req_dwords = 11'h001;
      wr_valid = 1'b0;
      wr_data = 128'h0;
      wr_strb = 16'h0000;
      rd_ready = 1'b1;
      slow = 1'b0;
      seq = 32'h0000_1000;
      wcnt = 8'h00;
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      test_fifo_fill();
      test_one_dword();
      test_two_dword_bme();
      test_strobe_mask();
      print_verdict();
   end
endmodule
